// ---- pkg/dmie_pkg.sv ----
package dmie_pkg;

    // Quarter phase of one instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} dmie_phase_t;

    // Operation held for the running instruction cycle
    typedef enum logic [2:0] {
        OP_NOP, OP_LPL1, OP_LPL2, OP_MVF, OP_MFF1, OP_MFF2, OP_LBL
    } dmie_op_t;

    // Second word that the next fetch must supply
    typedef enum logic [1:0] {EX_NONE, EX_LPL, EX_MFF} dmie_expect_t;

    // Data-space write request
    typedef struct packed {
        logic        en;
        logic [11:0] addr;
        logic [7:0]  data;
    } dmie_wr_t;

endpackage

// ---- pkg/dmie_regs.svh ----
// How it works
// - Pointer literal load writes 12-bit literal to chosen pointer; two words, no flags.
// - First word 1110 00 sel lit[11:8]; second word 1111 0000 lit[7:0].
// - Move file 0101 00da copies register to W (d=0) or back; sets N and Z.
// - Move file 8-bit address reaches any byte of the selected 256-byte bank.
// - Access bit 0 picks access bank, 1 picks bank select register bank.
// - Access bit 0 with extended set and address up to 5Fh uses indexed offset.
// - File-to-file move uses full 12-bit source and destination, no banking.
// - File-to-file move: 1100 source word, 1111 destination word; write in Q4.
// - File-to-file move never writes program counter low or return stack top.
// - File-to-file move reaches W through its data-space address.
// - Bank literal load sets low nibble of bank select; upper nibble reads zero.
`ifndef DMIE_REGS_SVH
`define DMIE_REGS_SVH

// ****************************************************************
// Register offsets on the AXI4-Lite bus
// ****************************************************************
`define DMIE_OFF_CTRL    12'h000
`define DMIE_OFF_STATUS  12'h004
`define DMIE_OFF_WREG    12'h008
`define DMIE_OFF_BANK    12'h00C
`define DMIE_OFF_PTR0    12'h010
`define DMIE_OFF_PTR1    12'h014
`define DMIE_OFF_PTR2    12'h018

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DMIE_CTRL_EXT    0
`define DMIE_ST_ZERO     0
`define DMIE_ST_NEG      1
`define DMIE_ST_BADDST   2
`define DMIE_RST_BYTE    8'h00
`define DMIE_RST_PTR     12'h000
`define DMIE_RST_NIB     4'h0

// ****************************************************************
// Data-space addresses of core registers
// ****************************************************************
`define DMIE_A_WREG      12'hFE8
`define DMIE_A_BANK      12'hFE0
`define DMIE_A_P0L       12'hFE9
`define DMIE_A_P0H       12'hFEA
`define DMIE_A_P1L       12'hFE1
`define DMIE_A_P1H       12'hFE2
`define DMIE_A_P2L       12'hFD9
`define DMIE_A_P2H       12'hFDA
`define DMIE_A_PC_LOW    12'hFF9
`define DMIE_A_RS_LOW    12'hFFD
`define DMIE_A_RS_HIGH   12'hFFE
`define DMIE_A_RS_UPPER  12'hFFF
`define DMIE_ACC_LIMIT   8'h5F
`define DMIE_ACC_HIGH    4'hF

// ****************************************************************
// Opcode patterns and AXI response codes
// ****************************************************************
`define DMIE_OP_LPL      6'b111000
`define DMIE_OP_LPL2     8'hF0
`define DMIE_OP_MVF      6'b010100
`define DMIE_OP_MFF      4'hC
`define DMIE_OP_MFF2     4'hF
`define DMIE_OP_LBL      8'h01
`define DMIE_RESP_OK     2'b00
`define DMIE_RESP_ERR    2'b10

`endif

// ---- rtl/dmie_core.sv ----
`timescale 1ns/1ns
`include "dmie_regs.svh"
// ****************************************************************
// Data move instruction decode and execute
// ****************************************************************
module dmie_core
    import dmie_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Instruction fetch stream
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    output logic             instr_ready_o,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    input  wire logic [11:0] s_axi_awaddr,
    output logic             s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_arready,
    output logic             s_axi_rvalid,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        s_axi_rready,
    // Execution status
    output logic             busy_o
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Byte operand address for a one-word byte instruction
    function automatic logic [11:0] eff_addr(input logic [7:0] f,
                                             input logic a,
                                             input logic [3:0] bank,
                                             input logic ext,
                                             input logic [11:0] p2);
        logic [11:0] r;
        r = {4'h0, f};
        if (a) begin
            r = {bank, f};
        end else if (ext && f <= `DMIE_ACC_LIMIT) begin
            r = p2 + {4'h0, f};
        end else if (f > `DMIE_ACC_LIMIT) begin
            r = {`DMIE_ACC_HIGH, f};
        end
        return r;
    endfunction

    // Destinations a file-to-file move may not write
    function automatic logic bad_dest(input logic [11:0] a);
        return a == `DMIE_A_PC_LOW || a == `DMIE_A_RS_LOW ||
               a == `DMIE_A_RS_HIGH || a == `DMIE_A_RS_UPPER;
    endfunction

    // AXI address maps to a register
    function automatic logic reg_hit(input logic [11:0] a);
        return a == `DMIE_OFF_CTRL || a == `DMIE_OFF_STATUS ||
               a == `DMIE_OFF_WREG || a == `DMIE_OFF_BANK ||
               a == `DMIE_OFF_PTR0 || a == `DMIE_OFF_PTR1 ||
               a == `DMIE_OFF_PTR2;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    dmie_phase_t  phase_q;
    dmie_op_t     op_q;
    dmie_expect_t exp_q;
    logic [15:0]  word_q;
    logic [11:0]  src_q;
    logic [7:0]   opnd_q;
    logic [7:0]   wreg_q;
    logic [3:0]   bank_q;
    logic [11:0]  ptr_q [0:2];
    logic         ext_q;
    logic         neg_q;
    logic         zero_q;
    logic         bad_q;
    logic [3:0]   lpl_hi_q;
    logic [1:0]   lpl_sel_q;
    logic [7:0]   ram_rdata;
    logic [7:0]   rd_val;
    logic         take;
    dmie_op_t     dec_op;
    dmie_wr_t     wr;
    dmie_wr_t     ram_wr;
    logic         sw_we;
    logic [11:0]  aw_addr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic         aw_hold_q;
    logic         w_hold_q;

    // ****************************************************************
    // Fetch and phase sequencing
    // ****************************************************************

    // A word is only taken at Q1; with none offered the core idles in Q1
    assign instr_ready_o = (phase_q == PH_Q1);
    assign take          = instr_ready_o && instr_valid_i;
    assign busy_o        = (phase_q != PH_Q1) || (exp_q != EX_NONE);

    // Decode the fetched word, honouring a pending second word
    always_comb begin
        dec_op = OP_NOP;
        if (exp_q == EX_LPL && instr_i[15:8] == `DMIE_OP_LPL2) begin
            dec_op = OP_LPL2;
        end else if (exp_q == EX_MFF &&
                     instr_i[15:12] == `DMIE_OP_MFF2) begin
            dec_op = OP_MFF2;
        end else if (instr_i[15:10] == `DMIE_OP_LPL) begin
            dec_op = OP_LPL1;
        end else if (instr_i[15:10] == `DMIE_OP_MVF) begin
            dec_op = OP_MVF;
        end else if (instr_i[15:12] == `DMIE_OP_MFF) begin
            dec_op = OP_MFF1;
        end else if (instr_i[15:8] == `DMIE_OP_LBL) begin
            dec_op = OP_LBL;
        end
    end

    // Four phases per instruction cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phase_q <= PH_Q1;
        end else begin
            unique case (phase_q)
                PH_Q1: if (take) phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_Q1;
            endcase
        end
    end

    // Latch the operation and word at Q1
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            op_q   <= OP_NOP;
            word_q <= 16'h0000;
        end else if (take) begin
            op_q   <= dec_op;
            word_q <= instr_i;
        end
    end

    // Track the second word owed by a two-word instruction
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            exp_q <= EX_NONE;
        end else if (take) begin
            unique case (dec_op)
                OP_LPL1: exp_q <= EX_LPL;
                OP_MFF1: exp_q <= EX_MFF;
                default: exp_q <= EX_NONE;
            endcase
        end
    end

    // ****************************************************************
    // Operand read
    // ****************************************************************

    // Source address fixed in Q2, RAM data valid in Q3
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            src_q <= `DMIE_RST_PTR;
        end else if (phase_q == PH_Q2) begin
            if (op_q == OP_MFF1) begin
                src_q <= word_q[11:0];
            end else begin
                src_q <= eff_addr(word_q[7:0], word_q[8], bank_q,
                                  ext_q, ptr_q[2]);
            end
        end
    end

    // Core registers answer at their data-space addresses
    always_comb begin
        unique case (src_q)
            `DMIE_A_WREG: rd_val = wreg_q;
            `DMIE_A_BANK: rd_val = {4'h0, bank_q};
            `DMIE_A_P0L:  rd_val = ptr_q[0][7:0];
            `DMIE_A_P0H:  rd_val = {4'h0, ptr_q[0][11:8]};
            `DMIE_A_P1L:  rd_val = ptr_q[1][7:0];
            `DMIE_A_P1H:  rd_val = {4'h0, ptr_q[1][11:8]};
            `DMIE_A_P2L:  rd_val = ptr_q[2][7:0];
            `DMIE_A_P2H:  rd_val = {4'h0, ptr_q[2][11:8]};
            default:      rd_val = ram_rdata;
        endcase
    end

    // Operand kept from Q4 of a source cycle to Q4 of the next
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            opnd_q <= `DMIE_RST_BYTE;
        end else if (phase_q == PH_Q4 &&
                     (op_q == OP_MFF1 || op_q == OP_MVF)) begin
            opnd_q <= rd_val;
        end
    end

    // ****************************************************************
    // Destination write in Q4
    // ****************************************************************

    // Move file writes back or to W; file-to-file writes without a read
    always_comb begin
        wr = '0;
        if (phase_q == PH_Q4) begin
            unique case (op_q)
                OP_MVF: begin
                    wr.en   = 1'b1;
                    wr.addr = word_q[9] ? src_q : `DMIE_A_WREG;
                    wr.data = rd_val;
                end
                OP_MFF2: begin
                    wr.en   = !bad_dest(word_q[11:0]);
                    wr.addr = word_q[11:0];
                    wr.data = opnd_q;
                end
                default: wr = '0;
            endcase
        end
    end

    // Core registers never land in RAM
    always_comb begin
        ram_wr = wr;
        unique case (wr.addr)
            `DMIE_A_WREG, `DMIE_A_BANK,
            `DMIE_A_P0L, `DMIE_A_P0H, `DMIE_A_P1L,
            `DMIE_A_P1H, `DMIE_A_P2L, `DMIE_A_P2H:
                ram_wr.en = 1'b0;
            default: ram_wr.en = wr.en;
        endcase
    end

    dmie_data_ram u_ram (
        .ref_clk_i (ref_clk_i),
        .rd_en_i   (phase_q == PH_Q2),
        .rd_addr_i ((op_q == OP_MFF1) ? word_q[11:0]
                    : eff_addr(word_q[7:0], word_q[8], bank_q,
                               ext_q, ptr_q[2])),
        .rd_data_o (ram_rdata),
        .wr_i      (ram_wr)
    );

    // ****************************************************************
    // Core registers (core writes win over software)
    // ****************************************************************
    assign sw_we = aw_hold_q && w_hold_q && !s_axi_bvalid;

    // Working register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wreg_q <= `DMIE_RST_BYTE;
        end else if (wr.en && wr.addr == `DMIE_A_WREG) begin
            wreg_q <= wr.data;
        end else if (sw_we && aw_addr_q == `DMIE_OFF_WREG &&
                     wstrb_q[0]) begin
            wreg_q <= wdata_q[7:0];
        end
    end

    // Bank select, only the low nibble exists
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bank_q <= `DMIE_RST_NIB;
        end else if (phase_q == PH_Q4 && op_q == OP_LBL) begin
            bank_q <= word_q[3:0];
        end else if (wr.en && wr.addr == `DMIE_A_BANK) begin
            bank_q <= wr.data[3:0];
        end else if (sw_we && aw_addr_q == `DMIE_OFF_BANK &&
                     wstrb_q[0]) begin
            bank_q <= wdata_q[3:0];
        end
    end

    // Pointer literal: high part and selector held from the first word
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lpl_hi_q  <= `DMIE_RST_NIB;
            lpl_sel_q <= 2'h0;
        end else if (phase_q == PH_Q4 && op_q == OP_LPL1) begin
            lpl_hi_q  <= word_q[3:0];
            lpl_sel_q <= word_q[9:8];
        end
    end

    // Pointer registers, one loop for the three of them
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                ptr_q[i] <= `DMIE_RST_PTR;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (phase_q == PH_Q4 && op_q == OP_LPL1 &&
                    word_q[9:8] == 2'(i)) begin
                    ptr_q[i][11:8] <= word_q[3:0];
                end else if (phase_q == PH_Q4 && op_q == OP_LPL2 &&
                             lpl_sel_q == 2'(i)) begin
                    ptr_q[i][7:0] <= word_q[7:0];
                    ptr_q[i][11:8] <= lpl_hi_q;
                end else if (wr.en && wr.addr ==
                             (i == 0 ? `DMIE_A_P0L :
                              i == 1 ? `DMIE_A_P1L : `DMIE_A_P2L)) begin
                    ptr_q[i][7:0] <= wr.data;
                end else if (wr.en && wr.addr ==
                             (i == 0 ? `DMIE_A_P0H :
                              i == 1 ? `DMIE_A_P1H : `DMIE_A_P2H)) begin
                    ptr_q[i][11:8] <= wr.data[3:0];
                end else if (sw_we && aw_addr_q == `DMIE_OFF_PTR0
                             + 12'(4 * i)) begin
                    if (wstrb_q[0]) ptr_q[i][7:0] <= wdata_q[7:0];
                    if (wstrb_q[1]) ptr_q[i][11:8] <= wdata_q[11:8];
                end
            end
        end
    end

    // Negative and zero flags from a move file value only
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            neg_q  <= 1'b0;
            zero_q <= 1'b0;
        end else if (phase_q == PH_Q4 && op_q == OP_MVF) begin
            neg_q  <= rd_val[7];
            zero_q <= (rd_val == 8'h00);
        end
    end

    // Sticky flag for a refused destination; a set wins over a clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bad_q <= 1'b0;
        end else if (phase_q == PH_Q4 && op_q == OP_MFF2 &&
                     bad_dest(word_q[11:0])) begin
            bad_q <= 1'b1;
        end else if (sw_we && aw_addr_q == `DMIE_OFF_STATUS &&
                     wstrb_q[0] && wdata_q[`DMIE_ST_BADDST]) begin
            bad_q <= 1'b0;
        end
    end

    // Extended instruction set enable
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ext_q <= 1'b0;
        end else if (sw_we && aw_addr_q == `DMIE_OFF_CTRL &&
                     wstrb_q[0]) begin
            ext_q <= wdata_q[`DMIE_CTRL_EXT];
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;

    // Address and data may come in either order
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (sw_we) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (sw_we) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Response one clock after both halves are held
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DMIE_RESP_OK;
        end else if (sw_we) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_addr_q) ? `DMIE_RESP_OK
                                               : `DMIE_RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    // Registered read data; unmapped offsets answer zero with an error
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DMIE_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= reg_hit(s_axi_araddr) ? `DMIE_RESP_OK
                                                  : `DMIE_RESP_ERR;
            unique case (s_axi_araddr)
                `DMIE_OFF_CTRL:   s_axi_rdata <= {31'h0, ext_q};
                `DMIE_OFF_STATUS: s_axi_rdata <= {29'h0, bad_q,
                                                  neg_q, zero_q};
                `DMIE_OFF_WREG:   s_axi_rdata <= {24'h0, wreg_q};
                `DMIE_OFF_BANK:   s_axi_rdata <= {28'h0, bank_q};
                `DMIE_OFF_PTR0:   s_axi_rdata <= {20'h0, ptr_q[0]};
                `DMIE_OFF_PTR1:   s_axi_rdata <= {20'h0, ptr_q[1]};
                `DMIE_OFF_PTR2:   s_axi_rdata <= {20'h0, ptr_q[2]};
                default:          s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // dmie_core

// ---- rtl/dmie_data_ram.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Data space memory, 4096 bytes, registered read
// ****************************************************************
module dmie_data_ram
    import dmie_pkg::*;
(
    // Clock
    input  wire logic        ref_clk_i,
    // Read port
    input  wire logic        rd_en_i,
    input  wire logic [11:0] rd_addr_i,
    output logic      [7:0]  rd_data_o,
    // Write port
    input  wire dmie_wr_t    wr_i
);

    logic [7:0] mem_q [0:4095];

    // Contents are not reset; software owns initial values
    always_ff @(posedge ref_clk_i) begin
        if (wr_i.en) begin
            mem_q[wr_i.addr] <= wr_i.data;
        end
    end

    // Read data from a register, one clock after the address
    always_ff @(posedge ref_clk_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end

endmodule // dmie_data_ram

// ---- verification/dmie_chk.sv ----
`timescale 1ns/1ns
// ******************************
// Fetch timing checks
// ******************************
module dmie_chk (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // Fetch stream and status
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic        instr_ready_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Words taken at a Q1 edge; selector 3 kept out, its length is open
    wire logic take  = instr_valid_i & instr_ready_o;
    wire logic w_ptr = take && instr_i[15:10] == 6'h38 && instr_i[9:8] != 2'h3;
    wire logic w_mff = take && instr_i[15:12] == 4'hC;
    wire logic w_lbl = take && instr_i[15:8] == 8'h01;
    wire logic w_mvf = take && instr_i[15:10] == 6'h14;
    sequence s_quad;
        busy_o [*3] ##1 !busy_o;
    endsequence
    sequence s_ptr_pair;
        w_ptr ##4 take && instr_i[15:8] == 8'hF0;
    endsequence
    sequence s_mff_pair;
        w_mff ##4 take && instr_i[15:12] == 4'hF;
    endsequence
    AST_GAP: assert property (take |=> !instr_ready_o [*3])
        else $error("fetch taken inside a cycle");
    AST_PTR_OWED: assert property (w_ptr |=> busy_o [*4])
        else $error("pointer load ended after one word");
    AST_PTR_END: assert property (s_ptr_pair |=> s_quad)
        else $error("pointer load not done after word two");
    AST_MFF_OWED: assert property (w_mff |=> busy_o [*4])
        else $error("file move ended after one word");
    AST_MFF_END: assert property (s_mff_pair |=> s_quad)
        else $error("file move not done after word two");
    AST_BANK_1C: assert property (w_lbl |=> s_quad)
        else $error("bank load not one cycle");
    AST_MOVE_1C: assert property (w_mvf |=> s_quad)
        else $error("move file not one cycle");
    AST_IDLE_RDY: assert property (!busy_o |-> instr_ready_o)
        else $error("idle but fetch not open");
endmodule // dmie_chk

bind dmie_core dmie_chk dmie_chk_inst (.ref_clk_i, .rst_n_i,
    .instr_valid_i, .instr_i, .instr_ready_o, .busy_o);

// ---- verification/dmie_core_tb.sv ----
`timescale 1ns/1ns
// ******************************
// Instruction and register bench
// ******************************
module dmie_core_tb;
    logic        ref_clk_i = 1'h0, rst_n_i = 1'h0, instr_valid_i = 1'h0;
    logic [15:0] instr_i = 16'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_bvalid, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        instr_ready_o, s_axi_awready, s_axi_wready;
    logic        s_axi_arready, busy_o;
    int          miscompares = 0, total_checks = 0, cyc = 0;
    dmie_core dmie_core_inst (.ref_clk_i, .rst_n_i, .instr_valid_i,
        .instr_i, .instr_ready_o, .s_axi_awvalid, .s_axi_awaddr,
        .s_axi_awready, .s_axi_wvalid, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
        .s_axi_arvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rvalid,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rready, .busy_o);
    // 50 MHz clock
    initial forever #10 ref_clk_i = ~ref_clk_i;
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // Ready is sampled at the falling edge so no race with the core
    task automatic fetch(input logic [15:0] w);
        instr_valid_i <= 1'h1;
        instr_i <= w;
        do @(negedge ref_clk_i); while (!instr_ready_o);
        @(posedge ref_clk_i);
    endtask
    task automatic idle();
        instr_valid_i <= 1'h0;
        do @(negedge ref_clk_i); while (busy_o);
        @(posedge ref_clk_i);
    endtask
    // Each half is released at its own handshake, in either order
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge ref_clk_i);
            aw_t = s_axi_awready;
            w_t = s_axi_wready;
            b_t = s_axi_bvalid;
            last_resp = s_axi_bresp;
            @(posedge ref_clk_i);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
        end while (!b_t);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        do @(negedge ref_clk_i); while (!s_axi_arready);
        @(posedge ref_clk_i);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(negedge ref_clk_i); while (!s_axi_rvalid);
        got = s_axi_rdata;
        last_resp = s_axi_rresp;
        @(posedge ref_clk_i);
        s_axi_rready <= 1'h0;
        chk(got, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        rdc(12'h008, 32'h0);
        wr(12'h008, 32'h80);
        fetch(16'hCFE8);
        fetch(16'hF123);
        idle();
        wr(12'h008, 32'h0);
        fetch(16'h01F1);
        idle();
        rdc(12'h00C, 32'h1);
        fetch(16'h5123);
        idle();
        rdc(12'h008, 32'h80);
        rdc(12'h004, 32'h2);
        fetch(16'hE103);
        fetch(16'hF0AB);
        idle();
        rdc(12'h014, 32'h3AB);
        fetch(16'hE30F);
        fetch(16'hF055);
        idle();
        rdc(12'h010, 32'h0);
        rdc(12'h018, 32'h0);
        fetch(16'hCFE8);
        fetch(16'hFFF9);
        idle();
        rdc(12'h004, 32'h6);
        wr(12'h000, 32'h1);
        chk(32'(last_resp), 32'h0);
        fetch(16'hE201);
        fetch(16'hF000);
        idle();
        wr(12'h008, 32'h0);
        fetch(16'h5023);
        idle();
        rdc(12'h008, 32'h80);
        wr(12'h004, 32'h4);
        wr(12'h008, 32'h0);
        fetch(16'h50E8);
        idle();
        rdc(12'h004, 32'h1);
        rdc(12'h020, 32'h0);
        chk(32'(last_resp), 32'h2);
        report_and_stop();
    end
endmodule // dmie_core_tb
